// file: dcs_host.sv
// Host processor model issuing control port I/O cycles
`timescale 1ns/1ps
`default_nettype none
module dcs_host (
    input  wire logic       clock,
    output logic            cs_n,
    output logic            rd_n,
    output logic            wr_n,
    output logic [3:0]      a,
    output logic [7:0]      d,
    output logic            smp
);
    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        a = 4'h0;
        d = 8'h5A;
        smp = 1'b0;
    end
    // Strobe held through take and answer edges, then one idle cycle
    task automatic acc(input logic w, input logic [3:0] ad, input logic [7:0] dv, input logic chk);
        @(posedge clock);
        cs_n <= 1'b0;
        rd_n <= w;
        wr_n <= !w;
        a <= ad;
        d <= w ? dv : ~d;
        repeat (2) @(posedge clock);
        smp <= chk && !w;
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        d <= ~d;
        @(posedge clock);
        smp <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: dcs_pkg.sv
// Package of codes, fields and reset values for the DMA control and status port
package dcs_pkg;
    localparam int NUM_CH = 4;
    // Register codes on the low three address lines (top line high)
    localparam logic [2:0] CODE_STATUS_CMD  = 3'h0;
    localparam logic [2:0] CODE_REQUEST     = 3'h1;
    localparam logic [2:0] CODE_CMD_SMASK   = 3'h2;
    localparam logic [2:0] CODE_MODE        = 3'h3;
    localparam logic [2:0] CODE_BYTE_PTR    = 3'h4;
    localparam logic [2:0] CODE_TEMP_MCLR   = 3'h5;
    localparam logic [2:0] CODE_MCNT_CMASK  = 3'h6;
    localparam logic [2:0] CODE_ALL_MASK    = 3'h7;
    // Field positions
    localparam int SEL_LSB      = 0;
    localparam int SET_BIT      = 2;
    localparam int MODE_LSB     = 2;
    localparam int MODE_W       = 6;
    localparam int XFER_LSB     = 6;
    localparam int AUTOINIT_BIT = 4;
    localparam int ACK_POL_BIT  = 7;
    // Transfer modes in mode bits 7:6
    localparam logic [1:0] XFER_DEMAND  = 2'h0;
    localparam logic [1:0] XFER_SINGLE  = 2'h1;
    localparam logic [1:0] XFER_BLOCK   = 2'h2;
    localparam logic [1:0] XFER_CASCADE = 2'h3;
    // Reset values and read fill values
    localparam logic [7:0] CMD_RST   = 8'h00;
    localparam logic [3:0] MASK_RST  = 4'hF;
    localparam logic [3:0] NIB_ONES  = 4'hF;
    localparam logic [1:0] LOW_ONES  = 2'h3;
    localparam logic [7:0] UNDEF_RD  = 8'h00;
endpackage

// file: dcs_port.sv
// Processor-facing command, status, mask and request logic of a four-channel DMA controller
`timescale 1ns/1ps
`default_nettype none

module dcs_port #(
    parameter int NCH = dcs_pkg::NUM_CH
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             chip_select_n,
    input  wire logic             io_read_strobe_n,
    input  wire logic             io_write_strobe_n,
    input  wire logic [3:0]       addr,
    input  wire logic [7:0]       data_in,
    output logic      [7:0]       data_out,
    output logic                  data_out_en,
    input  wire logic             hold_acknowledge,
    input  wire logic [NCH-1:0]   channel_transfer_request,
    input  wire logic [NCH-1:0]   terminal_count,
    input  wire logic [NCH-1:0]   end_of_process,
    input  wire logic             temp_load,
    input  wire logic [7:0]       temp_data,
    input  wire logic [NCH-1:0]   channel_ack_active,
    output logic      [NCH-1:0]   channel_acknowledge_output,
    output logic      [7:0]       command_value,
    output logic      [NCH-1:0]   mask_bits,
    output logic      [NCH-1:0]   soft_request_valid,
    output logic                  byte_pointer_high,
    output logic      [NCH*dcs_pkg::MODE_W-1:0] mode_values,
    output logic                  master_clear_pulse
);

    typedef struct packed {
        logic [7:0]                   cmd;
        logic [NCH-1:0]               req;
        logic [NCH-1:0]               mask;
        logic [NCH-1:0]               tc;
        logic [7:0]                   temp;
        logic                         bptr;
        logic [1:0]                   mcnt;
        logic [NCH*dcs_pkg::MODE_W-1:0] mode;
        logic                         rd_prev;
        logic                         wr_prev;
        logic [7:0]                   dout;
        logic                         mclr;
    } dcs_state_t;

    dcs_state_t s_q;
    dcs_state_t s_d;
    logic [1:0] rst_sync_q;
    logic       rst_int_n;
    logic [NCH-1:0] channel_transfer_request_pend_q;

    // Reset release through two flops
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_int_n = rst_sync_q[1];

    function automatic logic [dcs_pkg::MODE_W-1:0] mode_of(
        input logic [NCH*dcs_pkg::MODE_W-1:0] m,
        input logic [1:0]                    ch
    );
        mode_of = m[ch*dcs_pkg::MODE_W +: dcs_pkg::MODE_W];
    endfunction

    // Pending requests sampled while clock high, held from falling edge
    always_ff @(negedge clock or negedge rst_int_n) begin
        if (!rst_int_n) begin
            channel_transfer_request_pend_q <= '0;
        end else if (s_q.mclr) begin
            channel_transfer_request_pend_q <= '0;
        end else begin
            channel_transfer_request_pend_q <= channel_transfer_request;
        end
    end

    logic rd_cyc;
    logic wr_cyc;
    logic rd_start;
    logic wr_start;
    logic [2:0] code;
    logic       ctl_sel;

    assign rd_cyc   = !chip_select_n && !io_read_strobe_n && !hold_acknowledge;
    assign wr_cyc   = !chip_select_n && !io_write_strobe_n && !hold_acknowledge;
    assign rd_start = rd_cyc && !s_q.rd_prev;
    assign wr_start = wr_cyc && !s_q.wr_prev;
    assign code     = addr[2:0];
    assign ctl_sel  = addr[3];

    always_comb begin
        logic [7:0] rdata;
        logic [1:0] ch;
        logic       mc;
        s_d     = s_q;
        rdata   = dcs_pkg::UNDEF_RD;
        ch      = data_in[1:0];
        mc      = 1'b0;
        s_d.rd_prev = rd_cyc;
        s_d.wr_prev = wr_cyc;
        s_d.mclr    = 1'b0;
        if (temp_load) begin
            s_d.temp = temp_data;
        end
        // Host accesses, one action per strobe
        if (rd_start && !ctl_sel) begin
            s_d.bptr = !s_q.bptr;
        end
        if (wr_start && !ctl_sel) begin
            s_d.bptr = !s_q.bptr;
        end
        if (rd_start && ctl_sel) begin
            unique case (code)
                dcs_pkg::CODE_STATUS_CMD: begin
                    rdata = {channel_transfer_request_pend_q, s_q.tc};
                    s_d.tc = '0;
                end
                dcs_pkg::CODE_REQUEST:    rdata = {dcs_pkg::NIB_ONES, s_q.req};
                dcs_pkg::CODE_CMD_SMASK:  rdata = s_q.cmd;
                dcs_pkg::CODE_MODE: begin
                    rdata = {mode_of(s_q.mode, s_q.mcnt), dcs_pkg::LOW_ONES};
                    s_d.mcnt = s_q.mcnt + 2'h1;
                end
                dcs_pkg::CODE_BYTE_PTR:   s_d.bptr = 1'b1;
                dcs_pkg::CODE_TEMP_MCLR:  rdata = s_q.temp;
                dcs_pkg::CODE_MCNT_CMASK: s_d.mcnt = 2'h0;
                dcs_pkg::CODE_ALL_MASK:   rdata = {dcs_pkg::NIB_ONES, s_q.mask};
            endcase
            s_d.dout = rdata;
        end
        if (wr_start && ctl_sel) begin
            unique case (code)
                dcs_pkg::CODE_STATUS_CMD: s_d.cmd = data_in;
                dcs_pkg::CODE_REQUEST:    s_d.req[ch] = data_in[dcs_pkg::SET_BIT];
                dcs_pkg::CODE_CMD_SMASK:  s_d.mask[ch] = data_in[dcs_pkg::SET_BIT];
                dcs_pkg::CODE_MODE:
                    s_d.mode[ch*dcs_pkg::MODE_W +: dcs_pkg::MODE_W] =
                        data_in[7:dcs_pkg::MODE_LSB];
                dcs_pkg::CODE_BYTE_PTR:   s_d.bptr = 1'b0;
                dcs_pkg::CODE_TEMP_MCLR:  mc = 1'b1;
                dcs_pkg::CODE_MCNT_CMASK: s_d.mask = '0;
                dcs_pkg::CODE_ALL_MASK:   s_d.mask = data_in[NCH-1:0];
            endcase
        end
        // Terminal count set wins over the clear by read
        s_d.tc = s_d.tc | terminal_count | end_of_process;
        // End of process mask set wins over a host mask write
        for (int i = 0; i < NCH; i++) begin
            if (end_of_process[i] && !s_q.mode[i*dcs_pkg::MODE_W + dcs_pkg::AUTOINIT_BIT - dcs_pkg::MODE_LSB]) begin
                s_d.mask[i] = 1'b1;
            end
        end
        if (mc) begin
            s_d.cmd  = dcs_pkg::CMD_RST;
            s_d.req  = '0;
            s_d.mask = dcs_pkg::MASK_RST;
            s_d.tc   = '0;
            s_d.temp = '0;
            s_d.bptr = 1'b0;
            s_d.mcnt = 2'h0;
            s_d.mclr = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_int_n) begin
        if (!rst_int_n) begin
            s_q      <= '0;
            s_q.mask <= dcs_pkg::MASK_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Per-channel outputs
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            logic [1:0] xm;
            assign xm = s_q.mode[g*dcs_pkg::MODE_W + dcs_pkg::XFER_LSB - dcs_pkg::MODE_LSB +: 2];
            assign channel_acknowledge_output[g] =
                s_q.cmd[dcs_pkg::ACK_POL_BIT] ? channel_ack_active[g] : !channel_ack_active[g];
            assign soft_request_valid[g] = s_q.req[g] &&
                (xm == dcs_pkg::XFER_BLOCK || xm == dcs_pkg::XFER_SINGLE);
        end
    endgenerate

    assign data_out           = s_q.dout;
    assign data_out_en        = rd_cyc && ctl_sel;
    assign command_value      = s_q.cmd;
    assign mask_bits          = s_q.mask;
    assign byte_pointer_high  = s_q.bptr;
    assign mode_values        = s_q.mode;
    assign master_clear_pulse = s_q.mclr;

endmodule

`default_nettype wire

// file: dcs_port_monitor.sv
// Checker of the control port register writes and commands
`timescale 1ns/1ps
`default_nettype none
module dcs_port_monitor #(
    parameter int NCH = 4
) (
    input wire logic             clock,
    input wire logic             rst_n,
    input wire logic             chip_select_n,
    input wire logic             io_read_strobe_n,
    input wire logic             io_write_strobe_n,
    input wire logic [3:0]       addr,
    input wire logic [7:0]       data_in,
    input wire logic             hold_acknowledge,
    input wire logic [NCH-1:0]   end_of_process,
    input wire logic [NCH*6-1:0] mode_values,
    input wire logic [NCH-1:0]   mask_bits,
    input wire logic [7:0]       command_value,
    input wire logic             byte_pointer_high,
    input wire logic             master_clear_pulse,
    input wire logic             data_out_en
);
    logic pw_q, pr_q, ws, rs, w_t, r_t;
    // First cycle of each strobe is the taken one
    assign ws = !chip_select_n && !io_write_strobe_n && !hold_acknowledge;
    assign rs = !chip_select_n && !io_read_strobe_n && !hold_acknowledge;
    assign w_t = ws && !pw_q;
    assign r_t = rs && !pr_q;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pw_q <= 1'b0;
            pr_q <= 1'b0;
        end else begin
            pw_q <= ws;
            pr_q <= rs;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    mclr_regs_a: assert property (w_t && addr == 4'hD |=> mask_bits == 4'hF && command_value == 8'h00)
        else $error("master clear state");
    mclr_pulse_a: assert property (w_t && addr == 4'hD |-> ##[1:2] master_clear_pulse)
        else $error("no clear pulse");
    clr_mask_a: assert property (w_t && addr == 4'hE |=> mask_bits == 4'h0)
        else $error("mask not cleared");
    all_mask_a: assert property (w_t && addr == 4'hF |=> mask_bits == $past(data_in[3:0]))
        else $error("mask write lost");
    cmd_write_a: assert property (w_t && addr == 4'h8 |=> command_value == $past(data_in))
        else $error("command write lost");
    ptr_cmd_a: assert property ((w_t || r_t) && addr == 4'hC |=> byte_pointer_high == $past(r_t))
        else $error("pointer command");
    ptr_toggle_a: assert property ((w_t || r_t) && !addr[3] |=> byte_pointer_high != $past(byte_pointer_high))
        else $error("pointer toggle");
    eop_mask_a: assert property (end_of_process[1] && !mode_values[8] |=> mask_bits[1])
        else $error("end left unmasked");
    rd_drive_a: assert property (rs && addr[3] |-> data_out_en)
        else $error("read data not driven");
    cover property (w_t && addr == 4'hD);
    cover property (end_of_process[1]);
    cover property (r_t && addr == 4'hB);
endmodule
`default_nettype wire

// file: tb_dcs_port.sv
// Self-checking bench of the DMA control port
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; $display("unexpected at %0t: %h %h", $time, g, e); end end
module tb_dcs_port;
    logic        clock = 1'b0, rst_n = 1'b0, hold = 1'b0, tload = 1'b0, cs_n, rd_n, wr_n, smp;
    logic [3:0]  a, tc = 4'h0, eop = 4'h0, treq = 4'h0, ack = 4'h0, sr, es, ao;
    logic [7:0]  d, dout, dv, tdata = 8'h00, md[4];
    logic [31:0] r = 32'he05e;
    logic [7:0]  q[$];
    int          errors = 0, n_tests = 0;
    always #2.5 clock = ~clock;
    dcs_port i_dut (.clock, .rst_n, .chip_select_n(cs_n), .io_read_strobe_n(rd_n), .io_write_strobe_n(wr_n),
        .addr(a), .data_in(d), .data_out(dout), .data_out_en(), .hold_acknowledge(hold),
        .channel_transfer_request(treq), .terminal_count(tc), .end_of_process(eop), .temp_load(tload),
        .temp_data(tdata), .channel_ack_active(ack), .channel_acknowledge_output(ao), .command_value(),
        .mask_bits(), .soft_request_valid(sr), .byte_pointer_high(), .mode_values(), .master_clear_pulse());
    dcs_host i_host (.clock, .cs_n, .rd_n, .wr_n, .a, .d, .smp);
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic results;
        if (errors == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic rd(input logic [3:0] ad, input logic [7:0] e);
        q.push_back(e);
        i_host.acc(1'b0, ad, 8'h00, 1'b1);
    endtask
    task automatic wr(input logic [3:0] ad, input logic [7:0] v);
        i_host.acc(1'b1, ad, v, 1'b0);
    endtask
    always @(posedge clock) begin
        if (smp) begin
            dv = q.pop_front();
            `CHK(dout, dv)
        end
    end
    initial begin
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        rd(4'hF, 8'hFF);
        rd(4'h9, 8'hF0);
        r = xs(r);
        wr(4'hF, r[7:0]);
        rd(4'hF, {4'hF, r[3:0]});
        wr(4'hE, r[7:0]);
        rd(4'hF, 8'hF0);
        wr(4'hA, 8'h06);
        rd(4'hF, 8'hF4);
        wr(4'h9, 8'h04);
        wr(4'h9, 8'h05);
        rd(4'h9, 8'hF3);
        r = xs(r);
        wr(4'h8, r[7:0]);
        ack <= r[11:8];
        @(posedge clock);
        `CHK(ao, r[7] ? r[11:8] : ~r[11:8])
        for (int i = 0; i < 4; i++) begin
            r = xs(r);
            md[i] = {r[7:5], 1'b0, r[3:2], 2'(i)};
            es[i] = (i < 2) && (md[i][7:6] == 2'h1 || md[i][7:6] == 2'h2);
            wr(4'hB, md[i]);
        end
        `CHK(sr, es)
        i_host.acc(1'b0, 4'hE, 8'h00, 1'b0);
        for (int i = 0; i < 4; i++) rd(4'hB, {md[i][7:2], 2'h3});
        i_host.acc(1'b0, 4'hC, 8'h00, 1'b0);
        wr(4'h0, r[7:0]);
        i_host.acc(1'b0, 4'h1, 8'h00, 1'b0);
        wr(4'hC, r[7:0]);
        hold <= 1'b1;
        wr(4'hF, 8'h00);
        hold <= 1'b0;
        rd(4'hF, 8'hF4);
        eop <= 4'h2;
        @(posedge clock);
        eop <= 4'h0;
        rd(4'hF, 8'hF6);
        treq <= 4'hA;
        tc <= 4'h5;
        @(posedge clock);
        tc <= 4'h0;
        rd(4'h8, 8'hA7);
        rd(4'h8, 8'hA0);
        r = xs(r);
        tdata <= r[7:0];
        tload <= 1'b1;
        @(posedge clock);
        tload <= 1'b0;
        rd(4'hD, r[7:0]);
        treq <= 4'h0;
        wr(4'hD, r[7:0]);
        rd(4'hF, 8'hFF);
        rd(4'h9, 8'hF0);
        rd(4'h8, 8'h00);
        rd(4'hD, 8'h00);
        repeat (2) @(posedge clock);
        results();
    end
    initial begin
        #5000;
        errors++;
        results();
    end
endmodule
bind dcs_port dcs_port_monitor #(.NCH(NCH)) i_mon (.clock, .rst_n, .chip_select_n, .io_read_strobe_n,
    .io_write_strobe_n, .addr, .data_in, .hold_acknowledge, .end_of_process, .mode_values, .mask_bits,
    .command_value, .byte_pointer_high, .master_clear_pulse, .data_out_en);
`default_nettype wire
